// ===== logic/counter_config.sv
// Behaviour
// - one or two totalizers, or frequency counter
// - four input modes per enabled counter
// - separate mode settings per counter
// - direction from input or fixed setting
// - four controls, two from external inputs except for selects 0, 5, a and f
// - remaining controls from host register bits, except one held low by selects 5, a and f
// - four-bit source select per counter
// - frequency mode uses both counters
// - measure A, B, or both multiplexed
// - selectable input noise filter
// - raw pin states readable by host
// - disabled pulse outputs follow host bits
// - continuous unless one-shot, per output
// - stored configuration in force from power-up
// - override bit selects host registers
// - mode and direction bit encodings
// - override clear ignores host mode and source blocks
`timescale 1ns/1ps
module counter_config #(
  parameter logic [cfg_pkg::CFG_W-1:0] STORED_CFG = '0
) (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // field inputs, pins 1..8 at bits 0..7
  input wire logic [7:0] pins_in,
  // pulse generator levels from the pwm engines
  input wire logic [1:0] pulse_gen_in,
  // applied configuration and derived signals
  output cfg_pkg::cfg_t cfg_out,
  output cfg_pkg::ctl_t ctl_one_out,
  output cfg_pkg::ctl_t ctl_two_out,
  output logic [1:0] count_dir_up_out,
  output logic osc_tick_out,
  output logic [1:0] freq_chan_out,
  output logic [1:0] totalizer_on_out,
  output logic [7:0] pins_filt_out,
  output logic [7:0] out_pins_out
);
  import cfg_pkg::*;

  if (OSC_DIV < 1 || OSC_DIV > 16) begin : g_osc_chk
    $error("oscillator divider out of range");
  end
  if (MUX_DWELL < 2 || MUX_DWELL > 2048) begin : g_dwell_chk
    $error("mux dwell out of range");
  end

  ////////////////////////////////////////////////////////////////////
  // control source decode, one row per select code
  function automatic ctl_t decode_ctl(input logic [3:0] sel,
                                      input logic pa, input logic pb,
                                      input logic [3:0] host);
    ctl_t c;
    c = '{load: host[0], enable: host[1], clear: host[2],
          latch: host[3]};
    unique case (sel)
      4'h0: c = c;
      4'h1: begin c.clear = pb; c.latch = pa; end
      4'h2: begin c.enable = pb; c.latch = pa; end
      4'h3: begin c.load = pb; c.latch = pa; end
      4'h4: begin c.clear = pa; c.latch = pb; end
      4'h5: c.clear = 1'b0;
      4'h6: begin c.enable = pb; c.clear = pa; end
      4'h7: begin c.load = pb; c.clear = pa; end
      4'h8: begin c.enable = pa; c.latch = pb; end
      4'h9: begin c.enable = pa; c.clear = pb; end
      4'ha: c.enable = 1'b0;
      4'hb: begin c.load = pb; c.enable = pa; end
      4'hc: begin c.load = pa; c.latch = pb; end
      4'hd: begin c.load = pa; c.clear = pb; end
      4'he: begin c.load = pa; c.enable = pb; end
      4'hf: c.load = 1'b0;
    endcase
    return c;
  endfunction : decode_ctl

  function automatic logic [7:0] filt_div(input logic [1:0] s);
    unique case (s)
      2'h0: return FILT_DIV0;
      2'h1: return FILT_DIV1;
      2'h2: return FILT_DIV2;
      2'h3: return FILT_DIV3;
    endcase
  endfunction : filt_div

  ////////////////////////////////////////////////////////////////////
  // host registers
  logic override_mask_bit_ff, nxt_override_mask_bit;
  logic [7:0] host_ctl_ff, nxt_host_ctl;
  logic [7:0] host_out_ff, nxt_host_out;
  cfg_t host_cfg_ff, nxt_host_cfg;
  logic [31:0] prdata_ff, nxt_prdata;
  logic pready_ff, nxt_pready;
  logic pslverr_ff, nxt_pslverr;
  logic [7:0] pins_raw_ff;
  logic [7:0] pins_filt_ff, nxt_pins_filt;
  cfg_t cfg_ff, nxt_cfg;

  always_comb begin
    nxt_override_mask_bit = override_mask_bit_ff;
    nxt_host_ctl = host_ctl_ff;
    nxt_host_out = host_out_ff;
    nxt_host_cfg = host_cfg_ff;
    nxt_prdata = prdata_ff;
    nxt_pready = 1'b0;
    nxt_pslverr = 1'b0;
    if (psel_in && !penable_in) begin
      nxt_pready = 1'b1;
      nxt_prdata = '0;
      unique case (paddr_in)
        ADDR_CTRL: begin
          if (pwrite_in) begin
            nxt_override_mask_bit = pwdata_in[0];
            nxt_host_ctl = pwdata_in[15:8];
          end
          nxt_prdata = {16'h0000, host_ctl_ff, 7'h00,
                        override_mask_bit_ff};
        end
        ADDR_MODE: begin
          if (pwrite_in) begin
            nxt_host_cfg = cfg_t'(pwdata_in[CFG_W-1:0]);
          end
          nxt_prdata = 32'(host_cfg_ff);
        end
        ADDR_SRC: begin
          if (pwrite_in) begin
            nxt_host_cfg.cnt_one.src_sel = pwdata_in[3:0];
            nxt_host_cfg.cnt_two.src_sel = pwdata_in[7:4];
          end
          nxt_prdata = {24'h000000, host_cfg_ff.cnt_two.src_sel,
                        host_cfg_ff.cnt_one.src_sel};
        end
        ADDR_OUTS: begin
          if (pwrite_in) begin
            nxt_host_out = pwdata_in[7:0];
          end
          nxt_prdata = {24'h000000, host_out_ff};
        end
        ADDR_STORED: nxt_prdata = 32'(STORED_CFG);
        ADDR_PINS: nxt_prdata = {16'h0000, pins_filt_ff,
                                 pins_raw_ff};
        ADDR_STATUS: nxt_prdata = 32'(cfg_ff);
        default: nxt_pslverr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      override_mask_bit_ff <= 1'b0;
      host_ctl_ff <= 8'h00;
      host_out_ff <= 8'h00;
      host_cfg_ff <= '0;
      prdata_ff <= 32'h00000000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      override_mask_bit_ff <= nxt_override_mask_bit;
      host_ctl_ff <= nxt_host_ctl;
      host_out_ff <= nxt_host_out;
      host_cfg_ff <= nxt_host_cfg;
      prdata_ff <= nxt_prdata;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // applied configuration

  always_comb begin
    nxt_cfg = override_mask_bit_ff ? host_cfg_ff
                                   : cfg_t'(STORED_CFG);
    if (nxt_cfg.freq_mode) begin
      nxt_cfg.cnt_one.enable = 1'b0;
      nxt_cfg.cnt_two.enable = 1'b0;
      if (nxt_cfg.freq_sel == 2'b00) begin
        nxt_cfg.freq_sel = FREQ_A;
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      cfg_ff <= '0;
    end else begin
      cfg_ff <= nxt_cfg;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // input filter: pin must hold for several divided samples
  logic [7:0] filt_cnt_ff, nxt_filt_cnt;
  logic [1:0] stable_ff [8];
  logic [1:0] nxt_stable [8];
  logic filt_tick;

  always_comb begin
    filt_tick = (filt_cnt_ff + 8'h01) >= filt_div(cfg_ff.filt_sel);
    nxt_filt_cnt = filt_tick ? 8'h00 : filt_cnt_ff + 8'h01;
    nxt_pins_filt = pins_filt_ff;
    for (int i = 0; i < 8; i++) begin
      nxt_stable[i] = stable_ff[i];
      if (pins_raw_ff[i] == pins_filt_ff[i]) begin
        nxt_stable[i] = 2'h0;
      end else if (filt_tick) begin
        if (stable_ff[i] == FILT_SAMPLES) begin
          nxt_pins_filt[i] = pins_raw_ff[i];
          nxt_stable[i] = 2'h0;
        end else begin
          nxt_stable[i] = stable_ff[i] + 2'h1;
        end
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      filt_cnt_ff <= 8'h00;
      pins_raw_ff <= 8'h00;
      pins_filt_ff <= 8'h00;
      for (int i = 0; i < 8; i++) begin
        stable_ff[i] <= 2'h0;
      end
    end else begin
      filt_cnt_ff <= nxt_filt_cnt;
      pins_raw_ff <= pins_in;
      pins_filt_ff <= nxt_pins_filt;
      for (int i = 0; i < 8; i++) begin
        stable_ff[i] <= nxt_stable[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // derived control, direction, oscillator, channel mux, outputs
  ctl_t ctl_one_ff, nxt_ctl_one, ctl_two_ff, nxt_ctl_two;
  logic [1:0] dir_ff, nxt_dir;
  logic [3:0] osc_cnt_ff, nxt_osc_cnt;
  logic osc_ff, nxt_osc;
  logic [10:0] dwell_ff, nxt_dwell;
  logic [1:0] chan_ff, nxt_chan;
  logic [7:0] outp_ff, nxt_outp;

  function automatic logic dir_of(input cnt_cfg_t c, input logic pin);
    if (c.force_dir) begin
      return c.force_up;
    end
    return c.ext_dir ? pin : c.force_up;
  endfunction : dir_of

  always_comb begin
    nxt_ctl_one = decode_ctl(cfg_ff.cnt_one.src_sel, pins_filt_ff[2],
                             pins_filt_ff[3], host_ctl_ff[3:0]);
    nxt_ctl_two = decode_ctl(cfg_ff.cnt_two.src_sel, pins_filt_ff[6],
                             pins_filt_ff[7], host_ctl_ff[7:4]);
    nxt_dir[0] = dir_of(cfg_ff.cnt_one, pins_filt_ff[1]);
    nxt_dir[1] = dir_of(cfg_ff.cnt_two, pins_filt_ff[5]);
    nxt_osc = 1'b0;
    nxt_osc_cnt = osc_cnt_ff + 4'h1;
    if (osc_cnt_ff == 4'(OSC_DIV - 1)) begin
      nxt_osc_cnt = 4'h0;
      nxt_osc = 1'b1;
    end
    nxt_dwell = dwell_ff + 11'h001;
    nxt_chan = chan_ff;
    if (!cfg_ff.freq_mode) begin
      nxt_chan = 2'b00;
      nxt_dwell = 11'h000;
    end else if (cfg_ff.freq_sel != FREQ_AB) begin
      nxt_chan = cfg_ff.freq_sel;
      nxt_dwell = 11'h000;
    end else if (dwell_ff == 11'(MUX_DWELL - 1)) begin
      nxt_dwell = 11'h000;
      nxt_chan = (chan_ff == FREQ_A) ? FREQ_B : FREQ_A;
    end else if (chan_ff != FREQ_A && chan_ff != FREQ_B) begin
      nxt_chan = FREQ_A;
    end
    nxt_outp = host_out_ff;
    if (cfg_ff.pulse_en[0]) begin
      nxt_outp[0] = pulse_gen_in[0];
    end
    if (cfg_ff.pulse_en[1]) begin
      nxt_outp[4] = pulse_gen_in[1];
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      ctl_one_ff <= '0;
      ctl_two_ff <= '0;
      dir_ff <= 2'b00;
      osc_cnt_ff <= 4'h0;
      osc_ff <= 1'b0;
      dwell_ff <= 11'h000;
      chan_ff <= 2'b00;
      outp_ff <= 8'h00;
    end else begin
      ctl_one_ff <= nxt_ctl_one;
      ctl_two_ff <= nxt_ctl_two;
      dir_ff <= nxt_dir;
      osc_cnt_ff <= nxt_osc_cnt;
      osc_ff <= nxt_osc;
      dwell_ff <= nxt_dwell;
      chan_ff <= nxt_chan;
      outp_ff <= nxt_outp;
    end
  end

  assign prdata_out = prdata_ff;
  assign pready_out = pready_ff;
  assign pslverr_out = pslverr_ff;
  assign cfg_out = cfg_ff;
  assign ctl_one_out = ctl_one_ff;
  assign ctl_two_out = ctl_two_ff;
  assign count_dir_up_out = dir_ff;
  assign osc_tick_out = osc_ff;
  assign freq_chan_out = chan_ff;
  assign totalizer_on_out = {cfg_ff.cnt_two.enable,
                             cfg_ff.cnt_one.enable};
  assign pins_filt_out = pins_filt_ff;
  assign out_pins_out = outp_ff;
endmodule : counter_config

// ===== logic/cfg_pkg.sv
package cfg_pkg;
  // apb register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_MODE = 8'h04;
  localparam logic [7:0] ADDR_SRC = 8'h08;
  localparam logic [7:0] ADDR_OUTS = 8'h0c;
  localparam logic [7:0] ADDR_STORED = 8'h10;
  localparam logic [7:0] ADDR_PINS = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  // oscillator rate and base clock
  localparam int OSC_HZ = 10_000_000;
  localparam int CLK_HZ = 100_000_000;
  localparam int OSC_DIV = CLK_HZ / OSC_HZ;
  // mux dwell for dual-channel frequency measurement
  localparam int MUX_DWELL = 1024;
  // filter divisor table, index = filter select
  localparam int FILT_W = 2;
  localparam logic [7:0] FILT_DIV0 = 8'h01;
  localparam logic [7:0] FILT_DIV1 = 8'h04;
  localparam logic [7:0] FILT_DIV2 = 8'h10;
  localparam logic [7:0] FILT_DIV3 = 8'h40;
  localparam logic [1:0] FILT_SAMPLES = 2'h3;

  typedef enum logic [1:0] {
    MODE_PULSE_DIR = 2'b00,
    MODE_UP_DOWN = 2'b01,
    MODE_QUAD = 2'b10,
    MODE_OSC = 2'b11
  } in_mode_t;

  typedef enum logic [1:0] {
    FREQ_A = 2'b01,
    FREQ_B = 2'b10,
    FREQ_AB = 2'b11
  } freq_sel_t;

  // one counter's configuration
  typedef struct packed {
    logic enable;
    in_mode_t mode;
    logic force_dir;
    logic force_up;
    logic ext_dir;
    logic [3:0] src_sel;
  } cnt_cfg_t;

  // full configuration word
  typedef struct packed {
    logic freq_mode;
    logic [1:0] freq_sel;
    logic [1:0] filt_sel;
    logic [1:0] pulse_en;
    logic [1:0] one_shot;
    cnt_cfg_t cnt_two;
    cnt_cfg_t cnt_one;
  } cfg_t;

  localparam int CFG_W = $bits(cfg_t);

  // four control lines of one counter
  typedef struct packed {
    logic load;
    logic enable;
    logic clear;
    logic latch;
  } ctl_t;
endpackage : cfg_pkg

// ===== tb/counter_config_properties.sv
`timescale 1ns/1ps
module counter_config_properties (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  // apb
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic pready_out,
  input wire logic pslverr_out,
  // applied side
  input wire logic [1:0] pulse_gen_in,
  input cfg_pkg::cfg_t cfg_out,
  input wire logic [1:0] count_dir_up_out,
  input wire logic osc_tick_out,
  input wire logic [1:0] freq_chan_out,
  input wire logic [1:0] totalizer_on_out,
  input wire logic [7:0] out_pins_out
);
  import cfg_pkg::*;
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!nrst_in);
  AST_READY: assert property (
    psel_in && !penable_in |=> pready_out) else $error("no ready");
  AST_READY_PULSE: assert property (
    pready_out |=> !pready_out) else $error("ready too long");
  AST_ERR_READY: assert property (
    pslverr_out |-> pready_out) else $error("error without ready");
  AST_CFG_SYNC: assert property (
    $changed(cfg_out) |-> $past(psel_in && pwrite_in, 1) ||
    $past(psel_in && pwrite_in, 2) || !$past(nrst_in, 2))
    else $error("config changed without write");
  AST_OSC_GAP: assert property (
    osc_tick_out |=> !osc_tick_out [*8]) else $error("tick early");
  AST_OSC_PERIOD: assert property (
    osc_tick_out |-> ##10 osc_tick_out) else $error("tick late");
  AST_FREQ_GATE: assert property (
    cfg_out.freq_mode |-> totalizer_on_out == 2'h0)
    else $error("totalizer on in freq mode");
  AST_TOTAL_EN: assert property (
    !cfg_out.freq_mode |-> totalizer_on_out ==
    {cfg_out.cnt_two.enable, cfg_out.cnt_one.enable})
    else $error("totalizer enable wrong");
  AST_FREQ_IDLE: assert property (
    !cfg_out.freq_mode |=> freq_chan_out == 2'h0)
    else $error("channel outside freq mode");
  AST_PULSE_ONE: assert property (
    cfg_out.pulse_en[0] |=> out_pins_out[0] == $past(pulse_gen_in[0]))
    else $error("output one not pulse");
  AST_FORCE_DIR: assert property (
    cfg_out.cnt_one.force_dir |=>
    count_dir_up_out[0] == $past(cfg_out.cnt_one.force_up))
    else $error("forced direction wrong");
endmodule : counter_config_properties

bind counter_config counter_config_properties
  counter_config_properties_inst (
  .ref_clk_in(ref_clk_in), .nrst_in(nrst_in),
  .psel_in(psel_in), .penable_in(penable_in),
  .pwrite_in(pwrite_in), .pready_out(pready_out),
  .pslverr_out(pslverr_out), .pulse_gen_in(pulse_gen_in),
  .cfg_out(cfg_out), .count_dir_up_out(count_dir_up_out),
  .osc_tick_out(osc_tick_out), .freq_chan_out(freq_chan_out),
  .totalizer_on_out(totalizer_on_out), .out_pins_out(out_pins_out));

// ===== tb/host_model.sv
`timescale 1ns/1ps
module host_model (
  // clock and apb answer
  input wire logic ref_clk_in,
  input wire logic pready_in,
  input wire logic pslverr_in,
  input wire logic [31:0] prdata_in,
  // apb request
  output logic psel_out,
  output logic penable_out,
  output logic pwrite_out,
  output logic [7:0] paddr_out,
  output logic [31:0] pwdata_out
);
  import cfg_pkg::*;
  initial begin
    psel_out = 1'b0;
    penable_out = 1'b0;
    pwrite_out = 1'b0;
    paddr_out = 8'h00;
    pwdata_out = 32'h0;
  end
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] r, output logic e);
    @(posedge ref_clk_in);
    psel_out <= 1'b1;
    pwrite_out <= w;
    paddr_out <= a;
    pwdata_out <= d;
    @(posedge ref_clk_in);
    penable_out <= 1'b1;
    @(posedge ref_clk_in);
    while (pready_in !== 1'b1) begin
      @(posedge ref_clk_in);
    end
    r = prdata_in;
    e = pslverr_in;
    psel_out <= 1'b0;
    penable_out <= 1'b0;
  endtask : apb
  // every governed block written, override last in ctrl
  task automatic cfg_all(input logic [31:0] ctrl, mode, src, outs);
    logic [31:0] r;
    logic e;
    apb(1'b1, ADDR_MODE, mode, r, e);
    apb(1'b1, ADDR_SRC, src, r, e);
    apb(1'b1, ADDR_OUTS, outs, r, e);
    apb(1'b1, ADDR_CTRL, ctrl, r, e);
  endtask : cfg_all
endmodule : host_model

// ===== tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  import cfg_pkg::*;
  localparam logic [CFG_W-1:0] STORED = 29'h00a0300;
  logic ref_clk_in, nrst_in, psel, penable, pwrite, pready, pslverr, e;
  logic osc;
  logic [7:0] pins_in, paddr, filt, outp, outs, pv, h;
  logic [1:0] pulse_gen_in, dir, chan, tot;
  logic [31:0] pwdata, prdata, r;
  logic [31:0] seed = 32'h00008b53;
  cfg_t cfg_out, c, x;
  ctl_t ctl_one, ctl_two;
  cfg_t applied[$];
  int mismatches, check_count;
  counter_config #(.STORED_CFG(STORED)) counter_config_inst (
    .ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .pins_in(pins_in),
    .pulse_gen_in(pulse_gen_in), .cfg_out(cfg_out),
    .ctl_one_out(ctl_one), .ctl_two_out(ctl_two),
    .count_dir_up_out(dir), .osc_tick_out(osc),
    .freq_chan_out(chan), .totalizer_on_out(tot),
    .pins_filt_out(filt), .out_pins_out(outp));
  host_model host_model_inst (.ref_clk_in(ref_clk_in),
    .pready_in(pready), .pslverr_in(pslverr), .prdata_in(prdata),
    .psel_out(psel), .penable_out(penable), .pwrite_out(pwrite),
    .paddr_out(paddr), .pwdata_out(pwdata));
  ////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  function automatic cfg_t exp_cfg(cfg_t m);
    if (m.freq_mode) begin
      m.cnt_one.enable = 1'b0;
      m.cnt_two.enable = 1'b0;
      if (m.freq_sel == 2'b00) m.freq_sel = FREQ_A;
    end
    return m;
  endfunction : exp_cfg
  function automatic logic exp_dir(cnt_cfg_t n, logic pin);
    return (n.force_dir || !n.ext_dir) ? n.force_up : pin;
  endfunction : exp_dir
  function automatic logic [1:0] exp_tot(cfg_t m);
    return m.freq_mode ? 2'h0 : {m.cnt_two.enable, m.cnt_one.enable};
  endfunction : exp_tot
  function automatic logic [7:0] exp_out(cfg_t m, logic [7:0] o,
    logic [1:0] g);
    if (m.pulse_en[0]) o[0] = g[0];
    if (m.pulse_en[1]) o[4] = g[1];
    return o;
  endfunction : exp_out
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    check_count++;
    if (s !== x) begin
      mismatches++;
      $display("wrong value at %0t: saw %h want %h", $time, s, x);
    end
  endtask : chk
  task give_verdict();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict
  ////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk_in = 1'b0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end
  initial begin
    repeat (4000) @(posedge ref_clk_in);
    mismatches++;
    give_verdict();
  end
  initial begin
    nrst_in = 1'b0;
    pins_in = 8'h00;
    pulse_gen_in = 2'h0;
    repeat (8) @(posedge ref_clk_in);
    nrst_in <= 1'b1;
    repeat (4) @(posedge ref_clk_in);
    chk(cfg_out, STORED);
    chk(tot, 2'h3);
    host_model_inst.apb(1'b1, ADDR_MODE, xs(), r, e);
    repeat (4) @(posedge ref_clk_in);
    chk(cfg_out, STORED);
    $display("test stored done");
    for (int k = 0; k < 6; k++) begin
      r = xs();
      c = r[CFG_W-1:0];
      c.cnt_one.mode = in_mode_t'(k[1:0]);
      c.cnt_two.mode = in_mode_t'(~k[1:0]);
      c.freq_mode = k > 3;
      c.pulse_en = k[1:0];
      if (k[0]) c.cnt_one.src_sel = 4'h0;
      if (!k[0]) c.cnt_two.src_sel = 4'h0;
      x = exp_cfg(c);
      r = xs();
      outs = r[7:0];
      h = r[23:16];
      pulse_gen_in <= r[9:8];
      host_model_inst.cfg_all({16'h0, h, 8'h01}, {3'h0, c},
        {24'h0, c.cnt_two.src_sel, c.cnt_one.src_sel}, {24'h0, outs});
      applied.push_back(x);
      repeat (6) @(posedge ref_clk_in);
      chk(cfg_out, x);
      chk(tot, exp_tot(c));
      chk(outp, exp_out(c, outs, pulse_gen_in));
      if (!c.freq_mode && c.cnt_one.src_sel == 4'h0)
        chk(ctl_one, {h[0], h[1], h[2], h[3]});
      if (c.cnt_two.src_sel == 4'h0)
        chk(ctl_two, {h[4], h[5], h[6], h[7]});
      chk(dir[0], exp_dir(c.cnt_one, pins_in[1]));
      chk(dir[1], exp_dir(c.cnt_two, pins_in[5]));
      if (!x.freq_mode)
        chk(chan, 2'h0);
      else if (x.freq_sel != FREQ_AB)
        chk(chan, x.freq_sel);
      else
        chk(chan == FREQ_A || chan == FREQ_B, 1'b1);
      host_model_inst.apb(1'b0, ADDR_STATUS, 32'h0, r, e);
      chk(r, applied[$]);
      $display("test mode %0d done", k);
    end
    r = xs();
    pv = r[7:0];
    pins_in <= pv;
    repeat (400) @(posedge ref_clk_in);
    chk(filt, pv);
    host_model_inst.apb(1'b0, ADDR_PINS, 32'h0, r, e);
    chk(r[15:0], {pv, pv});
    host_model_inst.apb(1'b0, 8'h1c, 32'h0, r, e);
    chk(e, 1'b1);
    chk(r, 32'h0);
    $display("test pins done");
    host_model_inst.apb(1'b1, ADDR_CTRL, 32'h0, r, e);
    repeat (4) @(posedge ref_clk_in);
    chk(cfg_out, STORED);
    chk(outp, outs);
    $display("test release done");
    give_verdict();
  end
endmodule : testbench
